/* src/oam_defs.svh */
`ifndef OAM_DEFS_SVH
`define OAM_DEFS_SVH
// ---------------------------------------------------------------
// widths and register numbers
// ---------------------------------------------------------------
`define OAM_AW          32
`define OAM_WW          16
`define OAM_RNW         4
`define OAM_FIRST_REG   4'h0
// ---------------------------------------------------------------
// operating modes
// ---------------------------------------------------------------
`define OAM_OP_COMPACT  2'h0
`define OAM_OP_SEGMENT  2'h1
`define OAM_OP_LINEAR   2'h2
// ---------------------------------------------------------------
// addressing mode codes
// ---------------------------------------------------------------
`define OAM_M_REG       4'h0
`define OAM_M_IMM       4'h1
`define OAM_M_IND       4'h2
`define OAM_M_DIR       4'h3
`define OAM_M_IDX       4'h4
`define OAM_M_BASE      4'h5
`define OAM_M_BIDX      4'h6
`define OAM_M_REL       4'h7
`define OAM_M_RIDX      4'h8
// ---------------------------------------------------------------
// instruction classes
// ---------------------------------------------------------------
`define OAM_I_OTHER     3'h0
`define OAM_I_LOAD      3'h1
`define OAM_I_LDA       3'h2
`define OAM_I_CALL      3'h3
`define OAM_I_JUMP      3'h4
`define OAM_I_DECREMENT_JUMP_NONZERO      3'h5
// ---------------------------------------------------------------
// operand spaces
// ---------------------------------------------------------------
`define OAM_S_NONE      3'h0
`define OAM_S_REG       3'h1
`define OAM_S_INSTR     3'h2
`define OAM_S_DATA      3'h3
`define OAM_S_IO        3'h4
// ---------------------------------------------------------------
// pc offset from first word to the word after the displacement
// ---------------------------------------------------------------
`define OAM_PC_AFTER_DISP 32'h00000004
`endif

/* src/oam_pkg.sv */
package oam_pkg;
  typedef enum logic [2:0] {
    OAM_IDLE = 3'b001,
    OAM_DONE = 3'b010,
    OAM_FAIL = 3'b100
  } oam_state_t;
endpackage

/* src/oam_check.sv */
`include "oam_defs.svh"
// ---------------------------------------------------------------
// legality of a mode/instruction pair in the current operating mode
// ---------------------------------------------------------------
module oam_check
  import oam_pkg::*;
(
  input  wire logic [1:0] op_mode,     // operating mode
  input  wire logic [3:0] addr_mode,   // addressing mode
  input  wire logic [2:0] instr_class, // instruction class
  input  wire logic       io_access,   // opcode asks for io space
  input  wire logic [3:0] reg_a,       // base/address register
  input  wire logic [3:0] reg_x,       // index register
  output logic            legal        // pair is permitted
);
  function automatic logic is_first(input logic [3:0] r);
    return r == `OAM_FIRST_REG;
  endfunction

  function automatic logic load_like(input logic [2:0] c);
    return (c == `OAM_I_LOAD) || (c == `OAM_I_LDA);
  endfunction

  logic compact;
  assign compact = (op_mode == `OAM_OP_COMPACT);

  always_comb
  begin
    legal = 1'b1;
    case (addr_mode)
      `OAM_M_REG, `OAM_M_IMM, `OAM_M_DIR:
        legal = 1'b1;
      `OAM_M_IND:
        legal = !is_first(reg_a);
      `OAM_M_IDX:
        legal = !is_first(reg_x) && (compact || !io_access);
      `OAM_M_BASE:
        legal = !is_first(reg_a) && !io_access && (!compact || load_like(instr_class));
      `OAM_M_BIDX:
        legal = !is_first(reg_a) && !is_first(reg_x) && !io_access
                && (!compact || load_like(instr_class));
      `OAM_M_REL:
        legal = !compact || load_like(instr_class) || instr_class == `OAM_I_CALL
                || instr_class == `OAM_I_JUMP || instr_class == `OAM_I_DECREMENT_JUMP_NONZERO;
      `OAM_M_RIDX:
        legal = !compact;
      default:
        legal = 1'b0;
    endcase
    if (op_mode != `OAM_OP_COMPACT && op_mode != `OAM_OP_SEGMENT && op_mode != `OAM_OP_LINEAR)
      legal = 1'b0;
  end
endmodule

/* src/oam_unit.sv */
// Behaviour
// - compact direct: address from instruction, opcode space
// - compact indexed: field plus word index, data
// - compact based: displacement plus word base, data
// - compact based only for load, load-address
// - compact base-indexed: base plus index, data
// - compact base-indexed only load, load-address
// - compact relative: displacement plus pc low word
// - pc is word after displacement word
// - compact relative: load, lda, call, jump, decrement_jump_nonzero
// - no relative-indexed in compact mode
// - register mode: operand in register, sized
// - immediate: operand from instruction stream
// - indirect: register holds address, data or io
// - indirect memory: longword register, not first
// - indirect io: word register, not first
// - compact indirect: word register, not first
// - linear: 32-bit wrapping address arithmetic
`include "oam_defs.svh"
module oam_unit
  import oam_pkg::*;
(
  input  wire logic        clock,       // 100 MHz clock
  input  wire logic        rst,         // async reset, high
  input  wire logic        start,       // decode request pulse
  input  wire logic [1:0]  op_mode,     // compact/segment/linear
  input  wire logic [3:0]  addr_mode,   // addressing mode code
  input  wire logic [2:0]  instr_class, // instruction class
  input  wire logic        io_access,   // opcode selects io space
  input  wire logic [1:0]  size_in,     // operand size from opcode
  input  wire logic [3:0]  reg_a,       // base/address register number
  input  wire logic [3:0]  reg_x,       // index register number
  input  wire logic [31:0] reg_a_val,   // contents of reg_a
  input  wire logic [31:0] reg_x_val,   // contents of reg_x
  input  wire logic        x_long,      // index is a longword
  input  wire logic [31:0] field,       // address or displacement field
  input  wire logic [31:0] pc_first,    // address of first instr word
  input  wire logic [31:0] disp_len,    // bytes from first word past disp
  output logic             done,        // result valid pulse
  output logic             fault,       // illegal combination pulse
  output logic [31:0]      ea,          // effective address
  output logic [2:0]       space,       // operand space
  output logic [1:0]       size_out,    // operand size
  output logic [3:0]       reg_sel      // register for register operand
);
  // ---------------------------------------------------------------
  // address arithmetic
  // ---------------------------------------------------------------
  // compact addresses are one word; the upper half stays zero
  function automatic logic [31:0] add_addr(input logic [1:0] m, input logic [31:0] a,
                                           input logic [31:0] b);
    logic [31:0] s;
    s = a + b;
    if (m == `OAM_OP_COMPACT)
      return {16'h0000, s[15:0]};
    return s;
  endfunction

  logic        legal;
  logic [31:0] next_ea;
  logic [2:0]  next_space;
  logic [31:0] pc_rel;
  logic [31:0] x_ext;
  logic [31:0] a_eff;
  oam_state_t  state;

  oam_check u_check (
    .op_mode     (op_mode),
    .addr_mode   (addr_mode),
    .instr_class (instr_class),
    .io_access   (io_access),
    .reg_a       (reg_a),
    .reg_x       (reg_x),
    .legal       (legal)
  );

  // pc counts from the word after the displacement, not the opcode
  assign pc_rel = pc_first + disp_len;
  assign x_ext  = x_long ? reg_x_val : {{16{reg_x_val[15]}}, reg_x_val[15:0]};
  // compact and io use the word register only
  assign a_eff  = (op_mode == `OAM_OP_COMPACT || io_access)
                  ? {16'h0000, reg_a_val[15:0]} : reg_a_val;

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  always_comb
  begin
    next_ea    = 32'h00000000;
    next_space = `OAM_S_DATA;
    case (addr_mode)
      `OAM_M_REG:
        next_space = `OAM_S_REG;
      `OAM_M_IMM:
      begin
        next_ea    = add_addr(op_mode, pc_first, 32'h00000000);
        next_space = `OAM_S_INSTR;
      end
      `OAM_M_IND:
      begin
        next_ea    = a_eff;
        next_space = io_access ? `OAM_S_IO : `OAM_S_DATA;
      end
      `OAM_M_DIR:
      begin
        next_ea    = add_addr(op_mode, field, 32'h00000000);
        next_space = io_access ? `OAM_S_IO : `OAM_S_DATA;
      end
      `OAM_M_IDX:
        next_ea = add_addr(op_mode, field, x_ext);
      `OAM_M_BASE:
        next_ea = add_addr(op_mode, a_eff, field);
      `OAM_M_BIDX:
        next_ea = add_addr(op_mode, a_eff, x_ext);
      `OAM_M_REL:
      begin
        next_ea    = add_addr(op_mode, pc_rel, field);
        next_space = `OAM_S_INSTR;
      end
      `OAM_M_RIDX:
      begin
        next_ea    = add_addr(op_mode, add_addr(op_mode, pc_rel, field), x_ext);
        next_space = `OAM_S_INSTR;
      end
      default:
        next_space = `OAM_S_NONE;
    endcase
  end

  // ---------------------------------------------------------------
  // result registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state <= OAM_IDLE;
    else if (!start)
      state <= OAM_IDLE;
    else if (legal)
      state <= OAM_DONE;
    else
      state <= OAM_FAIL;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ea       <= 32'h00000000;
      space    <= `OAM_S_NONE;
      size_out <= 2'h0;
      reg_sel  <= 4'h0;
    end
    else if (start)
    begin
      ea       <= legal ? next_ea : 32'h00000000;
      space    <= legal ? next_space : `OAM_S_NONE;
      size_out <= size_in;
      reg_sel  <= reg_a;
    end
  end

  // ---------------------------------------------------------------
  // answer strobes
  // ---------------------------------------------------------------
  always_comb
  begin
    done  = 1'b0;
    fault = 1'b0;
    case (state)
      OAM_DONE:
        done = 1'b1;
      OAM_FAIL:
        fault = 1'b1;
      default:
      begin
        done  = 1'b0;
        fault = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_DIRECT: assert property (@(posedge clock) disable iff (rst)
    start && legal && addr_mode == `OAM_M_DIR && op_mode == `OAM_OP_COMPACT
    |=> done && ea == {16'h0000, $past(field[15:0])} && space == ($past(io_access) ? `OAM_S_IO : `OAM_S_DATA))
    else $error("direct address wrong");
  AST_INDEX: assert property (@(posedge clock) disable iff (rst)
    start && legal && addr_mode == `OAM_M_IDX && op_mode == `OAM_OP_COMPACT
    |=> ea[15:0] == 16'($past(field[15:0]) + $past(reg_x_val[15:0])) && space == `OAM_S_DATA)
    else $error("indexed address wrong");
  AST_BASE: assert property (@(posedge clock) disable iff (rst)
    start && legal && addr_mode == `OAM_M_BASE && op_mode == `OAM_OP_COMPACT
    |=> ea[15:0] == 16'($past(reg_a_val[15:0]) + $past(field[15:0])))
    else $error("based address wrong");
  AST_BASE_LOAD: assert property (@(posedge clock) disable iff (rst)
    start && op_mode == `OAM_OP_COMPACT && addr_mode == `OAM_M_BASE
    && instr_class != `OAM_I_LOAD && instr_class != `OAM_I_LDA |=> fault && !done)
    else $error("based mode accepted");
  AST_BIDX: assert property (@(posedge clock) disable iff (rst)
    start && (reg_a == 4'h0 || reg_x == 4'h0) && addr_mode == `OAM_M_BIDX |=> fault)
    else $error("base-indexed first register accepted");
  AST_BIDX_LOAD: assert property (@(posedge clock) disable iff (rst)
    start && op_mode == `OAM_OP_COMPACT && addr_mode == `OAM_M_BIDX && instr_class == `OAM_I_JUMP |=> fault)
    else $error("base-indexed jump accepted");
  AST_REL: assert property (@(posedge clock) disable iff (rst)
    start && legal && addr_mode == `OAM_M_REL && op_mode == `OAM_OP_COMPACT
    |=> ea[15:0] == 16'($past(pc_first[15:0]) + $past(disp_len[15:0]) + $past(field[15:0]))
    && space == `OAM_S_INSTR)
    else $error("relative address wrong");
  AST_REL_CLASS: assert property (@(posedge clock) disable iff (rst)
    start && op_mode == `OAM_OP_COMPACT && addr_mode == `OAM_M_REL && instr_class == `OAM_I_OTHER |=> fault)
    else $error("relative other accepted");
  AST_RIDX: assert property (@(posedge clock) disable iff (rst)
    start && op_mode == `OAM_OP_COMPACT && addr_mode == `OAM_M_RIDX |=> fault && space == `OAM_S_NONE)
    else $error("relative-indexed in compact");
  AST_REG: assert property (@(posedge clock) disable iff (rst)
    start && legal && addr_mode == `OAM_M_REG |=> space == `OAM_S_REG && size_out == $past(size_in))
    else $error("register operand wrong");
  AST_IND: assert property (@(posedge clock) disable iff (rst)
    start && legal && addr_mode == `OAM_M_IND && op_mode == `OAM_OP_LINEAR && !io_access
    |=> ea == $past(reg_a_val) && space == `OAM_S_DATA)
    else $error("indirect memory wrong");
  AST_IND_FIRST: assert property (@(posedge clock) disable iff (rst)
    start && addr_mode == `OAM_M_IND && reg_a == 4'h0 |=> fault ##1 !fault || $past(start))
    else $error("indirect first register accepted");
  AST_WRAP: assert property (@(posedge clock) disable iff (rst)
    start && legal && addr_mode == `OAM_M_IDX && op_mode == `OAM_OP_LINEAR && x_long
    |=> ea == 32'($past(field) + $past(reg_x_val)))
    else $error("linear wrap wrong");

  // ---------------------------------------------------------------
  // compact results, first-register refusals in any mode
  // ---------------------------------------------------------------
  AST_IND_CMP: assert property (@(posedge clock) disable iff (rst)
    start && legal && addr_mode == `OAM_M_IND && op_mode == `OAM_OP_COMPACT
    |=> ea == {16'h0000, $past(reg_a_val[15:0])} && space == ($past(io_access) ? `OAM_S_IO : `OAM_S_DATA))
    else $error("compact indirect wrong");
  AST_BIDX_ADDR: assert property (@(posedge clock) disable iff (rst)
    start && legal && addr_mode == `OAM_M_BIDX && op_mode == `OAM_OP_COMPACT
    |=> ea[15:0] == 16'($past(reg_a_val[15:0]) + $past(reg_x_val[15:0])) && space == `OAM_S_DATA)
    else $error("base-indexed address wrong");
  AST_CMP_UPPER: assert property (@(posedge clock) disable iff (rst)
    start && legal && op_mode == `OAM_OP_COMPACT |=> ea[31:16] == 16'h0000)
    else $error("compact address has upper half");
  AST_BASE_FIRST: assert property (@(posedge clock) disable iff (rst)
    start && addr_mode == `OAM_M_BASE && reg_a == 4'h0 |=> fault)
    else $error("based first register accepted");
  AST_IDX_FIRST: assert property (@(posedge clock) disable iff (rst)
    start && addr_mode == `OAM_M_IDX && reg_x == 4'h0 |=> fault)
    else $error("indexed first register accepted");
  AST_REL_OK: assert property (@(posedge clock) disable iff (rst)
    start && op_mode == `OAM_OP_COMPACT && addr_mode == `OAM_M_REL
    && instr_class inside {`OAM_I_LOAD, `OAM_I_LDA, `OAM_I_CALL, `OAM_I_JUMP, `OAM_I_DECREMENT_JUMP_NONZERO} |=> done)
    else $error("relative class refused");

  // ---------------------------------------------------------------
  // segmented and linear results, register number in any mode
  // ---------------------------------------------------------------
  AST_IMM: assert property (@(posedge clock) disable iff (rst)
    start && legal && addr_mode == `OAM_M_IMM && op_mode == `OAM_OP_LINEAR
    |=> ea == $past(pc_first) && space == `OAM_S_INSTR)
    else $error("immediate operand wrong");
  AST_SEG_IND: assert property (@(posedge clock) disable iff (rst)
    start && legal && addr_mode == `OAM_M_IND && op_mode == `OAM_OP_SEGMENT && !io_access
    |=> ea == $past(reg_a_val) && space == `OAM_S_DATA)
    else $error("segmented indirect wrong");
  AST_IND_IO: assert property (@(posedge clock) disable iff (rst)
    start && legal && addr_mode == `OAM_M_IND && op_mode != `OAM_OP_COMPACT && io_access
    |=> ea == {16'h0000, $past(reg_a_val[15:0])} && space == `OAM_S_IO)
    else $error("indirect io wrong");
  AST_LIN_BASE: assert property (@(posedge clock) disable iff (rst)
    start && legal && addr_mode == `OAM_M_BASE && op_mode == `OAM_OP_LINEAR
    |=> ea == 32'($past(reg_a_val) + $past(field)) && space == `OAM_S_DATA)
    else $error("linear based wrong");
  AST_RIDX_LIN: assert property (@(posedge clock) disable iff (rst)
    start && legal && addr_mode == `OAM_M_RIDX && op_mode == `OAM_OP_LINEAR && !x_long
    |=> ea == 32'($past(pc_first) + $past(disp_len) + $past(field)
                  + {{16{$past(reg_x_val[15])}}, $past(reg_x_val[15:0])})
    && space == `OAM_S_INSTR)
    else $error("linear relative-indexed wrong");
  AST_REG_SEL: assert property (@(posedge clock) disable iff (rst)
    start && legal && addr_mode == `OAM_M_REG |=> reg_sel == $past(reg_a))
    else $error("register operand number wrong");

  // ---------------------------------------------------------------
  // answer strobes, refusals and result hold
  // ---------------------------------------------------------------
  AST_ANSWER: assert property (@(posedge clock) disable iff (rst)
    start |=> done != fault)
    else $error("not exactly one answer");
  AST_IDLE: assert property (@(posedge clock) disable iff (rst)
    !start |=> !done && !fault)
    else $error("answer without request");
  AST_REFUSE_CLR: assert property (@(posedge clock) disable iff (rst)
    start && !legal |=> fault && ea == 32'h00000000 && space == `OAM_S_NONE)
    else $error("refusal left a result");
  AST_ILLEGAL_OP: assert property (@(posedge clock) disable iff (rst)
    start && op_mode == 2'h3 |=> fault)
    else $error("undefined operating mode accepted");
  AST_HOLD: assert property (@(posedge clock) disable iff (rst)
    !start |=> $stable(ea) && $stable(space) && $stable(size_out) && $stable(reg_sel))
    else $error("result changed without request");
endmodule

/* dv/oam_seq_model.sv */
// ---------------------------------------------------------------
// access sequencer side: tallies answers seen at the rising edge
// ---------------------------------------------------------------
module oam_seq_model
  import oam_pkg::*;
(
  input  wire logic clock,   // core clock
  input  wire logic rst,     // async reset, high
  input  wire logic done,    // operand located
  input  wire logic fault,   // combination refused
  output int        n_done,  // answers taken
  output int        n_fault  // refusals taken
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt_done  = 0;
  int cnt_fault = 0;
  assign n_done  = cnt_done;
  assign n_fault = cnt_fault;
  // tallies survive reset so the bench can compare whole-run totals
  always @(posedge clock)
  begin
    if (!rst && done === 1'b1)
      cnt_done++;
    if (!rst && fault === 1'b1)
      cnt_fault++;
  end
endmodule

/* dv/test_operand_address_mode_unit.sv */
`include "oam_defs.svh"
module test_operand_address_mode_unit
  import oam_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [1:0] CMP = `OAM_OP_COMPACT, SEG = `OAM_OP_SEGMENT, LIN = `OAM_OP_LINEAR;
  localparam logic [3:0] REG = `OAM_M_REG, IMM = `OAM_M_IMM, IND = `OAM_M_IND, DIR = `OAM_M_DIR;
  localparam logic [3:0] IDX = `OAM_M_IDX, BAS = `OAM_M_BASE, BIX = `OAM_M_BIDX, REL = `OAM_M_REL;
  localparam logic [3:0] RIX = `OAM_M_RIDX;
  localparam logic [2:0] OTH = `OAM_I_OTHER, LD = `OAM_I_LOAD, LDA = `OAM_I_LDA, JMP = `OAM_I_JUMP;
  localparam logic [2:0] NON = `OAM_S_NONE, RGS = `OAM_S_REG, INS = `OAM_S_INSTR, DAT = `OAM_S_DATA;
  localparam logic [2:0] IOS = `OAM_S_IO;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        start = 1'b0;
  logic [1:0]  op_mode = 2'h0;
  logic [3:0]  addr_mode = 4'h0;
  logic [2:0]  instr_class = 3'h0;
  logic        io_access = 1'b0;
  logic [1:0]  size_in = 2'h0;
  logic [3:0]  reg_a = 4'h0;
  logic [3:0]  reg_x = 4'h0;
  logic [31:0] reg_a_val = 32'h0;
  logic [31:0] reg_x_val = 32'h0;
  logic        x_long = 1'b0;
  logic [31:0] field = 32'h0;
  logic [31:0] pc_first = 32'h0;
  logic [31:0] disp_len = `OAM_PC_AFTER_DISP;
  logic        done, fault;
  logic [31:0] ea;
  logic [2:0]  space;
  logic [1:0]  size_out;
  logic [3:0]  reg_sel;
  int          errors = 0, comparisons = 0, n_ok = 0, n_bad = 0, m_done, m_fault;

  always #5 clock = ~clock;

  oam_unit i_dut (.clock(clock), .rst(rst), .start(start), .op_mode(op_mode), .addr_mode(addr_mode),
    .instr_class(instr_class), .io_access(io_access), .size_in(size_in), .reg_a(reg_a), .reg_x(reg_x),
    .reg_a_val(reg_a_val), .reg_x_val(reg_x_val), .x_long(x_long), .field(field), .pc_first(pc_first),
    .disp_len(disp_len), .done(done), .fault(fault), .ea(ea), .space(space), .size_out(size_out),
    .reg_sel(reg_sel));
  oam_seq_model i_seq (.clock(clock), .rst(rst), .done(done), .fault(fault), .n_done(m_done),
    .n_fault(m_fault));

  // ---------------------------------------------------------------
  // shared checks and requests
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // entered at a falling edge, leaves start high so calls run back to back
  task automatic op(input logic [1:0] om, input logic [3:0] am, input logic [2:0] ic, input logic io,
                    input logic [3:0] ra, input logic [3:0] rx, input logic [31:0] av, input logic [31:0] xv,
                    input logic [31:0] fl, input logic [31:0] xea, input logic [2:0] xsp);
    op_mode = om;
    addr_mode = am;
    instr_class = ic;
    io_access = io;
    reg_a = ra;
    reg_x = rx;
    reg_a_val = av;
    reg_x_val = xv;
    field = fl;
    start = 1'b1;
    @(posedge clock);
    @(negedge clock);
    if (xsp != NON)
      n_ok++;
    else
      n_bad++;
    chk(32'(done), 32'(xsp != NON));
    chk(32'(fault), 32'(xsp == NON));
    if (xsp != RGS)
      chk(ea, xea);
    chk(32'(space), 32'(xsp));
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_compact();
    op(CMP, DIR, LD, 1'b0, 4'h0, 4'h0, 32'h0, 32'h0, 32'h12345E23, 32'h5E23, DAT);
    op(CMP, DIR, OTH, 1'b1, 4'h0, 4'h0, 32'h0, 32'h0, 32'h0040, 32'h0040, IOS);
    op(CMP, IDX, LD, 1'b0, 4'h0, 4'h7, 32'h0, 32'h01FE, 32'h231A, 32'h2518, DAT);
    op(CMP, BAS, LD, 1'b0, 4'h5, 4'h0, 32'h20AA, 32'h0, 32'h0018, 32'h20C2, DAT);
    op(CMP, BAS, LDA, 1'b0, 4'h5, 4'h0, 32'h20AA, 32'h0, 32'h0018, 32'h20C2, DAT);
    op(CMP, BIX, LD, 1'b0, 4'h5, 4'h3, 32'h1502, 32'hFFFE, 32'h0, 32'h1500, DAT);
    op(CMP, BIX, LDA, 1'b0, 4'h5, 4'h3, 32'h1502, 32'hFFFE, 32'h0, 32'h1500, DAT);
    op(CMP, IND, LD, 1'b0, 4'h5, 4'h0, 32'h170A, 32'h0, 32'h0, 32'h170A, DAT);
    op(CMP, IND, OTH, 1'b1, 4'h5, 4'h0, 32'h0080, 32'h0, 32'h0, 32'h0080, IOS);
  endtask

  task automatic t_relative();
    pc_first = 32'h00031000;
    for (int k = 1; k <= 5; k++)
      op(CMP, REL, 3'(k), 1'b0, 4'h0, 4'h0, 32'h0, 32'h0, 32'h0002, 32'h1006, INS);
    pc_first = 32'h0000FFF0;
    disp_len = 32'h6;
    // low word wraps, the carry out of it must not reach the upper half
    op(CMP, REL, JMP, 1'b0, 4'h0, 4'h0, 32'h0, 32'h0, 32'h0010, 32'h0006, INS);
    disp_len = `OAM_PC_AFTER_DISP;
  endtask

  task automatic t_refuse();
    op(CMP, BAS, OTH, 1'b0, 4'h5, 4'h0, 32'h20AA, 32'h0, 32'h18, 32'h0, NON);
    op(CMP, BAS, LD, 1'b0, 4'h0, 4'h0, 32'h20AA, 32'h0, 32'h18, 32'h0, NON);
    op(CMP, BIX, JMP, 1'b0, 4'h5, 4'h3, 32'h1502, 32'h2, 32'h0, 32'h0, NON);
    op(CMP, BIX, LD, 1'b0, 4'h0, 4'h3, 32'h1502, 32'h2, 32'h0, 32'h0, NON);
    op(CMP, REL, OTH, 1'b0, 4'h0, 4'h0, 32'h0, 32'h0, 32'h2, 32'h0, NON);
    op(CMP, RIX, LD, 1'b0, 4'h0, 4'h7, 32'h0, 32'h4, 32'h2, 32'h0, NON);
    op(CMP, IDX, LD, 1'b0, 4'h0, 4'h0, 32'h0, 32'h4, 32'h231A, 32'h0, NON);
    op(CMP, IND, LD, 1'b0, 4'h0, 4'h0, 32'h170A, 32'h0, 32'h0, 32'h0, NON);
    op(LIN, IND, LD, 1'b0, 4'h0, 4'h0, 32'h0002170C, 32'h0, 32'h0, 32'h0, NON);
    op(SEG, IND, OTH, 1'b1, 4'h0, 4'h0, 32'hABCD, 32'h0, 32'h0, 32'h0, NON);
    op(2'h3, DIR, LD, 1'b0, 4'h0, 4'h0, 32'h0, 32'h0, 32'h5E23, 32'h0, NON);
    op(LIN, 4'hF, LD, 1'b0, 4'h0, 4'h0, 32'h0, 32'h0, 32'h0, 32'h0, NON);
  endtask

  task automatic t_wide();
    for (int k = 0; k < 4; k++)
    begin
      size_in = 2'(k);
      op(k[0] ? LIN : SEG, REG, LD, 1'b0, 4'h9, 4'h0, 32'h0, 32'h0, 32'h0, 32'h0, RGS);
      chk(32'(size_out), 32'(k));
      chk(32'(reg_sel), 32'h9);
    end
    pc_first = 32'h00031000;
    op(LIN, IMM, LD, 1'b0, 4'h0, 4'h0, 32'h0, 32'h0, 32'h0, 32'h00031000, INS);
    op(LIN, RIX, LD, 1'b0, 4'h0, 4'h7, 32'h0, 32'hFFFE, 32'h0010, 32'h00031012, INS);
    op(LIN, IND, LD, 1'b0, 4'h4, 4'h0, 32'h0002170C, 32'h0, 32'h0, 32'h0002170C, DAT);
    op(SEG, IND, LD, 1'b0, 4'h4, 4'h0, 32'h0002170C, 32'h0, 32'h0, 32'h0002170C, DAT);
    op(LIN, IND, OTH, 1'b1, 4'h2, 4'h0, 32'hABCD, 32'h0, 32'h0, 32'hABCD, IOS);
    op(LIN, BAS, LD, 1'b0, 4'h4, 4'h0, 32'hFFFFFFF0, 32'h0, 32'h0020, 32'h10, DAT);
    op(LIN, IDX, LD, 1'b0, 4'h0, 4'h7, 32'h0, 32'h0020, 32'hFFFFFFF0, 32'h10, DAT);
    op(LIN, IDX, LD, 1'b0, 4'h0, 4'h7, 32'h0, 32'hFFFE, 32'h1000, 32'h0FFE, DAT);
    x_long = 1'b1;
    op(LIN, IDX, LD, 1'b0, 4'h0, 4'h7, 32'h0, 32'hFFFE, 32'h1000, 32'h00010FFE, DAT);
  endtask

  task automatic t_hold_and_reset();
    start = 1'b0;
    @(posedge clock);
    @(negedge clock);
    chk(32'(done), 32'h0);
    chk(ea, 32'h00010FFE);
    chk(32'(space), 32'(DAT));
    rst = 1'b1;
    #1;
    chk(ea, 32'h0);
    chk(32'(space), 32'h0);
    chk(32'(fault), 32'h0);
    @(negedge clock);
    rst = 1'b0;
    x_long = 1'b0;
    op(CMP, DIR, LD, 1'b0, 4'h0, 4'h0, 32'h0, 32'h0, 32'h5E23, 32'h5E23, DAT);
    start = 1'b0;
    @(negedge clock);
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    repeat (5) @(negedge clock);
    chk(32'(done), 32'h0);
    chk(ea, 32'h0);
    rst = 1'b0;
    t_compact();
    t_relative();
    t_refuse();
    t_wide();
    t_hold_and_reset();
    chk(32'(m_done), 32'(n_ok));
    chk(32'(m_fault), 32'(n_bad));
    finish_test();
  end

  initial
  begin
    #100000;
    errors++;
    finish_test();
  end
endmodule
